/* src/rst_seq_consts.svh */
/*
 Constants for the reset sequencer: register map, cause-flag bit positions
 and reference-clock cycle counts.
 Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef RST_SEQ_CONSTS_SVH
`define RST_SEQ_CONSTS_SVH

// APB register byte addresses
`define ADDR_CAUSE       12'h000
`define ADDR_WDOG_CLEAR  12'h004
`define ADDR_CONTROL     12'h008
`define ADDR_VECTOR      12'h00C
`define ADDR_SEQ_STATUS  12'h010

// Cause register bit positions, most significant first
`define BIT_POR          7
`define BIT_EXT          6
`define BIT_WDOG         5
`define BIT_BADOP        4
`define BIT_BADADDR      3
`define BIT_MON          2
`define BIT_UV           1
`define CAUSE_POR_VALUE  8'h82

// Control register bits
`define BIT_STOP_EN      0
`define CONTROL_RESET    1'b0

// Cycle counts of the reference clock
`define OSC_STAB_CYCLES  13'h1000
`define PIN_HOLD_CYCLES  13'h0020
`define INT_HOLD_CYCLES  13'h0020
`define EXT_MIN_CYCLES   13'h0004

// Vector locations, bus clock divider reset value and watchdog counter width and top
`define VEC_HIGH_ADDR    16'hFFFE
`define VEC_LOW_ADDR     16'hFFFF
`define BUS_DIV_RESET    2'h2
`define WDOG_WIDTH       16
`define WDOG_TOP         16'hFFFF

`endif

/* src/rst_seq_pkg.sv */
/*
 Types shared by the reset sequencer.
 Assumes the constants header is on the include path.
*/
package rst_seq_pkg;
	typedef enum logic [5:0]
	{
		st_run     = 6'b000001,
		st_stab    = 6'b000010,
		st_pin_low = 6'b000100,
		st_hold    = 6'b001000,
		st_vec_hi  = 6'b010000,
		st_vec_lo  = 6'b100000
	} seq_state_type;
endpackage

/* src/wdog_counter.sv */
/*
 Watchdog counter: free-running count cleared by software, pulses on overflow.
 Assumes it is held clear while the device is in reset.
*/
`include "rst_seq_consts.svh"

module wdog_counter
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic resetn,
	// Control
	input  wire logic hold_clear,
	input  wire logic service,
	// Event
	output logic      overflow
);
	logic [`WDOG_WIDTH-1:0] count;
	wire at_top = (count == `WDOG_TOP);

	always_ff @(posedge mclk)
	begin
		if (!resetn || hold_clear || service)
			count <= '0;
		else
			count <= count + 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			overflow <= 1'b0;
		else
			overflow <= at_top && !hold_clear && !service;
	end
endmodule

/* src/mcu_reset_sequencer.sv */
/*
 Reset sequencer: gathers reset requests, stretches the reset pin, holds the
 core in reset, fetches the reset vector and records reset causes in a
 read-to-clear register reached over APB.
 Assumes mclk is the oscillator reference clock and that inputs are
 synchronous to it. The reset pin is open drain with an external pullup.
*/
// Decided for this implementation: the APB slave port and the register offsets.
`include "rst_seq_consts.svh"

module mcu_reset_sequencer
	import rst_seq_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Reset sources
	input  wire logic        por_req,
	input  wire logic        supply_low,
	input  wire logic        opcode_fetch,
	input  wire logic        opcode_illegal,
	input  wire logic        opcode_is_stop,
	input  wire logic        fetch_unmapped,
	input  wire logic        data_unmapped,
	input  wire logic        monitor_force,
	// Reset pin, open drain
	input  wire logic        rst_pin_in,
	output logic             rst_pin_out,
	output logic             rst_pin_oe_n,
	// Core side
	output logic             core_reset,
	output logic             clocks_enable,
	output logic             abort_instr,
	output logic [1:0]       bus_clk_div,
	output logic             vec_read,
	output logic [15:0]      vec_addr,
	input  wire logic [7:0]  vec_data,
	output logic [15:0]      pc_load,
	output logic             pc_load_valid
);
	seq_state_type state;
	seq_state_type next_state;
	logic [12:0] count;
	logic [12:0] next_count;
	logic [7:0]  cause;
	logic [7:0]  next_cause;
	logic        stop_enable;
	logic [12:0] ext_low_count;
	logic        ext_seen;
	logic        sample_pending;
	logic [7:0]  vec_high;
	logic        wdog_overflow;

	// APB decode
	wire apb_setup   = psel && !penable;
	wire apb_access  = psel && penable;
	wire apb_write   = apb_access && pwrite;
	wire apb_read    = apb_access && !pwrite;
	wire hit_cause   = (paddr == `ADDR_CAUSE);
	wire hit_wdog    = (paddr == `ADDR_WDOG_CLEAR);
	wire hit_control = (paddr == `ADDR_CONTROL);
	wire hit_vector  = (paddr == `ADDR_VECTOR);
	wire hit_status  = (paddr == `ADDR_SEQ_STATUS);
	wire hit_any     = hit_cause | hit_wdog | hit_control | hit_vector | hit_status;
	// Cause register accepts no write; a write to it is an error
	wire bad_access  = !hit_any || (pwrite && (hit_cause || hit_vector || hit_status));
	wire cause_read  = apb_read && hit_cause;
	wire wdog_write  = apb_write && hit_wdog;

	// Request decode
	wire req_stop    = opcode_fetch && opcode_is_stop && !stop_enable;
	wire req_badop   = opcode_fetch && (opcode_illegal || req_stop);
	wire req_badaddr = opcode_fetch && fetch_unmapped;
	wire ext_req     = ext_low_count >= `EXT_MIN_CYCLES;
	wire req_long    = por_req || supply_low;
	wire req_short   = wdog_overflow || req_badop || req_badaddr || monitor_force;
	wire in_reset    = (state != st_run);

	wdog_counter watchdog
	(
		.mclk       (mclk),
		.resetn     (resetn),
		.hold_clear (in_reset),
		.service    (wdog_write),
		.overflow   (wdog_overflow)
	);

	// Sequencer
	always_comb
	begin
		next_state = state;
		next_count = count + 1'b1;
		if (req_long)
		begin
			next_state = st_stab;
			next_count = '0;
		end
		else if (req_short)
		begin
			next_state = st_pin_low;
			next_count = '0;
		end
		else if (ext_req && state == st_run)
		begin
			next_state = st_hold;
			next_count = '0;
		end
		else
		begin
			unique case (state)
				st_run:
					next_count = '0;
				st_stab:
					if (count == `OSC_STAB_CYCLES - 1'b1)
					begin
						next_state = st_pin_low;
						next_count = '0;
					end
				st_pin_low:
					if (count == `PIN_HOLD_CYCLES - 1'b1)
					begin
						next_state = st_hold;
						next_count = '0;
					end
				st_hold:
					if (count == `INT_HOLD_CYCLES - 1'b1)
					begin
						next_state = st_vec_hi;
						next_count = '0;
					end
				st_vec_hi:
					next_state = st_vec_lo;
				st_vec_lo:
					next_state = st_run;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			state <= st_stab;
			count <= '0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
		end
	end

	// External pin watch and release sampling
	always_ff @(posedge mclk)
	begin
		if (!resetn || rst_pin_in || !rst_pin_oe_n)
			ext_low_count <= '0;
		else if (!ext_req)
			ext_low_count <= ext_low_count + 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			sample_pending <= 1'b0;
		else
			sample_pending <= (state == st_hold);
	end

	// Pin checked as hold ends, 32 cycles after release
	assign ext_seen = (ext_req && state == st_run) ||
		(sample_pending && state == st_vec_hi && !rst_pin_in);

	// Cause flags: set wins over the read clear
	always_comb
	begin
		next_cause = cause_read ? 8'h00 : cause;
		if (por_req)
			next_cause = `CAUSE_POR_VALUE;
		else
		begin
			if (supply_low)
				next_cause[`BIT_UV] = 1'b1;
			if (wdog_overflow)
				next_cause[`BIT_WDOG] = 1'b1;
			if (req_badop)
				next_cause[`BIT_BADOP] = 1'b1;
			if (req_badaddr)
				next_cause[`BIT_BADADDR] = 1'b1;
			if (monitor_force)
				next_cause[`BIT_MON] = 1'b1;
			if (ext_seen)
				next_cause[`BIT_EXT] = 1'b1;
		end
		next_cause[0] = 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			cause <= `CAUSE_POR_VALUE;
		else
			cause <= next_cause;
	end

	// Control register
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			stop_enable <= `CONTROL_RESET;
		else if (apb_write && hit_control)
			stop_enable <= pwdata[`BIT_STOP_EN];
	end

	// APB read data and response
	wire [31:0] read_mux =
		hit_cause   ? {24'h00_0000, cause} :
		hit_control ? {31'h0000_0000, stop_enable} :
		hit_vector  ? {16'h0000, pc_load} :
		hit_status  ? {26'h000_0000, state} : 32'h0000_0000;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= apb_setup;
			pslverr <= apb_setup && bad_access;
			prdata  <= (apb_setup && !pwrite) ? read_mux : 32'h0000_0000;
		end
	end

	// Core-side outputs, all registered
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			rst_pin_out   <= 1'b0;
			rst_pin_oe_n  <= 1'b0;
			core_reset    <= 1'b1;
			clocks_enable <= 1'b0;
			abort_instr   <= 1'b1;
			bus_clk_div   <= `BUS_DIV_RESET;
			vec_read      <= 1'b0;
			vec_addr      <= `VEC_HIGH_ADDR;
			vec_high      <= '0;
			pc_load       <= '0;
			pc_load_valid <= 1'b0;
		end
		else
		begin
			rst_pin_out   <= 1'b0;
			rst_pin_oe_n  <= !(next_state == st_stab || next_state == st_pin_low);
			core_reset    <= (next_state != st_run);
			clocks_enable <= (next_state != st_stab);
			abort_instr   <= (next_state != st_run);
			if (next_state != st_run)
				bus_clk_div <= `BUS_DIV_RESET;
			vec_read      <= (next_state == st_vec_hi || next_state == st_vec_lo);
			vec_addr      <= (next_state == st_vec_lo) ? `VEC_LOW_ADDR : `VEC_HIGH_ADDR;
			pc_load_valid <= 1'b0;
			if (state == st_vec_hi)
				vec_high <= vec_data;
			if (state == st_vec_lo && next_state == st_run)
			begin
				pc_load       <= {vec_high, vec_data};
				pc_load_valid <= 1'b1;
			end
		end
	end

	// Checks
	chk_internal_pin_low: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(state == st_pin_low) && !req_long |=> !rst_pin_oe_n [*8])
		else $error("reset pin not driven low after internal request");
	chk_hold_after_pin: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(rst_pin_oe_n) |-> core_reset)
		else $error("core left reset at pin release");
	chk_cause_reserved: assert property (@(posedge mclk) disable iff (!resetn)
		cause[0] == 1'b0)
		else $error("reserved cause bit set");
	chk_read_clears: assert property (@(posedge mclk) disable iff (!resetn)
		cause_read && !por_req && !req_short && !supply_low && !ext_seen |=> cause == 8'h00)
		else $error("cause not cleared by read");
	chk_por_flags: assert property (@(posedge mclk) disable iff (!resetn)
		por_req |=> cause == `CAUSE_POR_VALUE)
		else $error("power-on flags wrong");
	chk_wdog_flag: assert property (@(posedge mclk) disable iff (!resetn)
		wdog_overflow && !por_req |=> cause[`BIT_WDOG] ##1 core_reset)
		else $error("watchdog reset not recorded");
	chk_data_no_reset: assert property (@(posedge mclk) disable iff (!resetn)
		state == st_run && data_unmapped && !req_long && !req_short && !ext_req
		|=> state == st_run)
		else $error("data access caused reset");
	chk_stab_clocks: assert property (@(posedge mclk) disable iff (!resetn)
		state == st_stab |-> !clocks_enable)
		else $error("clocks running during stabilisation");
	chk_vec_order: assert property (@(posedge mclk) disable iff (!resetn)
		state == st_vec_hi && !req_long && !req_short |=> vec_addr == `VEC_LOW_ADDR)
		else $error("vector fetch order wrong");

	cov_por: cover property (@(posedge mclk) disable iff (!resetn) por_req);
	cov_wdog: cover property (@(posedge mclk) disable iff (!resetn) wdog_overflow);
	cov_ext: cover property (@(posedge mclk) disable iff (!resetn) ext_seen);
	cov_pc: cover property (@(posedge mclk) disable iff (!resetn) pc_load_valid);
endmodule

/* bench/reset_pin_peer.sv */
/*
 Far-side party on the open-drain reset pin: pulls low on request.
 Assumes an external pullup, so a released pin reads high.
*/
module reset_pin_peer
(
	// Clock
	input  wire logic mclk,
	// Device side of the pin
	input  wire logic dev_out,
	input  wire logic dev_oe_n,
	// Pull request and wire level
	input  wire logic pull_req,
	output logic      pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic peer_low = 1'b0;
	always_ff @(posedge mclk)
	begin
		peer_low <= pull_req;
	end
	// Pullup wins when nobody pulls
	assign pin_level = !((!dev_oe_n && !dev_out) || peer_low);
endmodule

/* bench/tb_top.sv */
/*
 Self-checking bench for the reset sequencer.
 Assumes the design's constants header is on the include path.
*/
`include "rst_seq_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pull_req = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, por_req = 0, supply_low = 0, opcode_fetch = 0;
	logic opcode_illegal = 0, opcode_is_stop = 0, fetch_unmapped = 0;
	logic data_unmapped = 0, monitor_force = 0, rst_pin_in, rst_pin_out;
	logic rst_pin_oe_n, core_reset, clocks_enable, abort_instr, vec_read;
	logic pc_load_valid;
	logic [1:0] bus_clk_div;
	logic [15:0] vec_addr, pc_load;
	logic [7:0] vec_data;
	logic [4:0] mon;
	int fail_count = 0, total_checks = 0;
	assign vec_data = vec_addr[0] ? 8'h34 : 8'h12;
	assign mon = {clocks_enable, rst_pin_oe_n, vec_read, pc_load_valid, core_reset};
	always #50 mclk = ~mclk;
	mcu_reset_sequencer dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .por_req(por_req), .supply_low(supply_low),
		.opcode_fetch(opcode_fetch), .opcode_illegal(opcode_illegal),
		.opcode_is_stop(opcode_is_stop), .fetch_unmapped(fetch_unmapped),
		.data_unmapped(data_unmapped), .monitor_force(monitor_force),
		.rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
		.core_reset(core_reset), .clocks_enable(clocks_enable), .abort_instr(abort_instr),
		.bus_clk_div(bus_clk_div), .vec_read(vec_read), .vec_addr(vec_addr),
		.vec_data(vec_data), .pc_load(pc_load), .pc_load_valid(pc_load_valid));
	reset_pin_peer peer (.mclk(mclk), .dev_out(rst_pin_out), .dev_oe_n(rst_pin_oe_n),
		.pull_req(pull_req), .pin_level(rst_pin_in));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Counts cycles while a watched output keeps level v
	task automatic span(input int b, input logic v, input int lim, output int n);
		n = 0;
		while (mon[b] === v && n < lim)
		begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic reg_chk(input string nm, input logic wr, input logic [11:0] a,
		input logic [31:0] e, input logic e_err);
		logic [31:0] rd;
		logic err;
		@(posedge mclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= e;
		@(posedge mclk);
		penable <= 1;
		// Only the bench time limit ends a wait that never sees pready
		do
		begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (!wr)
			chk(nm, e, rd);
		chk("pslverr", 32'(e_err), 32'(err));
	endtask
	task automatic fire(input int k);
		@(posedge mclk);
		opcode_fetch <= (k < 3);
		opcode_illegal <= (k == 0);
		opcode_is_stop <= (k == 1);
		fetch_unmapped <= (k == 2);
		monitor_force <= (k == 3);
		data_unmapped <= (k == 4);
		@(posedge mclk);
		{opcode_fetch, opcode_illegal, opcode_is_stop} <= '0;
		{fetch_unmapped, monitor_force, data_unmapped} <= '0;
	endtask
	task automatic run_seq(input bit long_seq);
		int n;
		span(3, 1, 20, n);
		if (long_seq)
		begin
			span(4, 0, 5000, n);
			chk("stab_cycles", 32'h0000_1000, n);
		end
		span(3, 0, 100, n);
		chk("pin_low", 32'h0000_0020, n);
		span(2, 0, 100, n);
		chk("hold", 32'h0000_0020, n);
		chk("abort", 32'h0000_0001, 32'(abort_instr));
		chk("bus_div", 32'h0000_0002, 32'(bus_clk_div));
		chk("vec_hi", 32'h0000_FFFE, 32'(vec_addr));
		@(posedge mclk);
		chk("vec_lo", 32'h0000_FFFF, 32'(vec_addr));
		span(1, 0, 4, n);
		chk("pc_load", 32'h0000_1234, 32'(pc_load));
	endtask
	task automatic t_por;
		// Count from the first cycle out of reset
		@(posedge mclk);
		run_seq(1);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_0082, 0);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_0000, 0);
		reg_chk("cause_wr", 1, `ADDR_CAUSE, 32'h0000_00FF, 1);
		reg_chk("unmapped", 0, 12'h0FC, 32'h0000_0000, 1);
	endtask
	task automatic t_opcode;
		int n;
		fire(0);
		run_seq(0);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_0010, 0);
		fire(1);
		run_seq(0);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_0010, 0);
		reg_chk("ctrl", 1, `ADDR_CONTROL, 32'h0000_0001, 0);
		fire(1);
		span(0, 0, 40, n);
		chk("stop_ok", 32'h0000_0028, n);
		reg_chk("ctrl", 1, `ADDR_CONTROL, 32'h0000_0000, 0);
	endtask
	task automatic t_accum;
		int n;
		fire(2);
		run_seq(0);
		fire(3);
		run_seq(0);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_000C, 0);
		fire(4);
		span(0, 0, 40, n);
		chk("data_acc", 32'h0000_0028, n);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_0000, 0);
	endtask
	task automatic t_ext;
		int n;
		@(posedge mclk);
		pull_req <= 1;
		repeat (8) @(posedge mclk);
		pull_req <= 0;
		span(0, 1, 200, n);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_0040, 0);
		// Peer keeps the pin low past release until the first vector fetch cycle ends
		fire(0);
		pull_req <= 1;
		span(3, 1, 20, n);
		span(3, 0, 100, n);
		repeat (31) @(posedge mclk);
		pull_req <= 0;
		span(0, 1, 200, n);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_0050, 0);
	endtask
	task automatic t_supply;
		@(posedge mclk);
		supply_low <= 1;
		repeat (20) @(posedge mclk);
		chk("uv_pin", 32'h0000_0000, 32'(rst_pin_oe_n));
		chk("pin_out", 32'h0000_0000, 32'(rst_pin_out));
		supply_low <= 0;
		@(posedge mclk);
		run_seq(1);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_0002, 0);
		// Power-on pulse must wipe the monitor flag left pending here
		fire(3);
		run_seq(0);
		@(posedge mclk);
		por_req <= 1;
		@(posedge mclk);
		por_req <= 0;
		run_seq(1);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_0082, 0);
	endtask
	task automatic t_wdog;
		int n;
		// Let the count run ahead so a lost clear shows up early
		repeat (100) @(posedge mclk);
		reg_chk("wdog_clr", 1, `ADDR_WDOG_CLEAR, 32'h0000_5A5A, 0);
		span(0, 0, 70000, n);
		chk("wdog_late", 32'h0000_0001, 32'(n > `WDOG_TOP));
		chk("wdog_fired", 32'h0000_0001, 32'(core_reset));
		run_seq(0);
		reg_chk("cause", 0, `ADDR_CAUSE, 32'h0000_0020, 0);
	endtask
	task automatic complete_run;
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		resetn <= 1;
		t_por;
		t_opcode;
		t_accum;
		t_ext;
		t_supply;
		t_wdog;
		complete_run;
	end
	// Run should end near 8 ms
	initial
	begin
		#9_000_000;
		fail_count++;
		complete_run;
	end
endmodule
